/* File: hdl/fsk_tx_pkg.sv */
// Constants, register map and carrier types for the FSK transmit framer.
// Assumes a 32-bit APB master; register indices are word indices (byte address = 4 * index).
package fsk_tx_pkg;

  // ==========================================================================
  // Register indices
  localparam logic [9:0] IDX_PREAMBLE   = 10'h102;
  localparam logic [9:0] IDX_SYNC_LOW   = 10'h10c;
  localparam logic [9:0] IDX_SYNC_MID   = 10'h10d;
  localparam logic [9:0] IDX_SYNC_HIGH  = 10'h10e;
  localparam logic [9:0] IDX_RADIO_CFG  = 10'h13e;
  localparam logic [9:0] IDX_PKT_CFG    = 10'h140;
  localparam logic [9:0] IDX_COMMAND    = 10'h141;
  localparam logic [9:0] IDX_STATUS     = 10'h142;
  localparam logic [9:0] IDX_TX_BASE    = 10'h314;
  localparam logic [9:0] IDX_PRE_EXTRA  = 10'h3f3;

  // ==========================================================================
  // Field positions
  localparam int PKT_CFG_CRC_OFF  = 0;
  localparam int PKT_CFG_GAUSS_EN = 1;
  localparam int CMD_TX_GO        = 0;
  localparam int CMD_LEAVE        = 1;
  localparam int STATUS_BUSY      = 3;

  // ==========================================================================
  // Reset values and encodings
  localparam logic [7:0]  RST_PREAMBLE  = 8'h04;
  localparam logic [7:0]  RST_PRE_EXTRA = 8'h00;
  localparam logic [7:0]  RST_SYNC      = 8'h00;
  localparam logic [7:0]  RST_RADIO_CFG = 8'h00;
  localparam logic [7:0]  RST_PKT_CFG   = 8'h00;
  localparam logic [7:0]  RST_TX_BASE   = 8'h00;
  localparam logic [15:0] CRC_INIT      = 16'h0000;
  localparam logic [15:0] CRC_POLY      = 16'h1021;
  localparam logic [7:0]  PAD_BYTE      = 8'haa;
  localparam logic [7:0]  MODE_RAW_TX   = 8'h03;
  localparam logic [7:0]  MODE_PKT_TX   = 8'h04;
  localparam logic [15:0] BODY_MIN      = 16'h0002;
  localparam logic [15:0] BODY_MAX      = 16'h0081;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_CAL  = 3'b001,
    ST_PRE  = 3'b011,
    ST_SYNC = 3'b010,
    ST_BODY = 3'b110,
    ST_CRC  = 3'b111,
    ST_POST = 3'b101,
    ST_RAW  = 3'b100
  } tx_state_t;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } apb_rsp_t;

endpackage

/* File: hdl/fsk_tx_packet_framer.sv */
// FSK transmit framer: APB register slave, packet-mode framing and raw serial transmit.
// Assumes a packet RAM with a one-cycle read port on clk_i and a modulator that pulses
// bit_tick_i once per bit period (at least two clocks apart) on the same clock.
//
// Behaviour
// - Preamble is repeated 0xaa bytes, programmable length.
// - Preamble bytes equal main plus extra count.
// - Sync sent MSB first, highest register first.
// - Sync always whole bytes; software pads short words.
// - Payload length spans sync end to CRC.
// - CRC-16 uses x^16 + x^12 + x^5 + 1.
// - CRC-off field set omits CRC; resets clear.
// - Two 0xaa postamble bytes follow CRC immediately.
// - PA ramp-down starts after first postamble byte.
// - Preamble 1-511, sync, length, payload 0-127, CRC.
// - Only length and payload come from packet RAM.
// - Sync length matters to receiver; transmitter sends padded.
// - Raw mode streams serial bits until leave command.
// - Raw mode raises no sync-sent or packet-sent events.
// - Raw mode runs same calibration on entry.
// - Raw latency two bits Gaussian, half bit otherwise; code: three bit ticks Gaussian, one otherwise.
// - Frame read starts at transmit base pointer.
//
// The implementer's own choice: register access over APB.
`timescale 1ns/1ps

module fsk_tx_packet_framer (
  // Clock and reset
  input  wire  logic                 clk_i,
  input  wire  logic                 rst_n_i,
  // Register bus
  input  wire  fsk_tx_pkg::apb_req_t apb_i,
  output       fsk_tx_pkg::apb_rsp_t apb_o,
  // Packet RAM read port
  output       logic [7:0]           pram_addr_o,
  input  wire  logic [7:0]           pram_rdata_i,
  // Modulator side
  input  wire  logic                 bit_tick_i,
  input  wire  logic                 serial_bit_i,
  input  wire  logic                 cal_done_i,
  output       logic                 tx_bit_o,
  output       logic                 tx_active_o,
  output       logic                 cal_start_o,
  output       logic                 pa_ramp_down_o,
  // Events
  output       logic                 sfd_sent_o,
  output       logic                 pkt_sent_o
);
  import fsk_tx_pkg::*;

  // ==========================================================================
  // State
  typedef struct packed {
    tx_state_t   st;
    logic [7:0]  shreg;
    logic [2:0]  bitcnt;
    logic [9:0]  cnt;
    logic [7:0]  addr;
    logic [7:0]  len_hi;
    logic [15:0] blen;
    logic [15:0] crc;
    logic [1:0]  dly;
    logic        ser_meta;
    logic        ser_sync;
    logic        raw_mode;
    logic        cal_start;
    logic        pa_down;
    logic        sfd_sent;
    logic        pkt_sent;
    logic [7:0]  preamble;
    logic [7:0]  pre_extra;
    logic [7:0]  sync_low;
    logic [7:0]  sync_mid;
    logic [7:0]  sync_high;
    logic [7:0]  radio_cfg;
    logic [7:0]  pkt_cfg;
    logic [7:0]  tx_base;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } framer_t;

  framer_t s;
  framer_t next_s;

  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic b);
    crc_step = {c[14:0], 1'b0} ^ ((c[15] ^ b) ? CRC_POLY : 16'h0000);
  endfunction

  function automatic logic [15:0] clamp_len(input logic [15:0] v);
    if (v < BODY_MIN) begin
      clamp_len = BODY_MIN;
    end else if (v > BODY_MAX) begin
      clamp_len = BODY_MAX;
    end else begin
      clamp_len = v;
    end
  endfunction

  logic [9:0]  idx;
  logic        wr_en;
  logic        rd_en;
  logic        mapped;
  logic [31:0] rdval;
  logic        byte_end;
  logic [15:0] crc_n;
  logic [15:0] body_total;
  logic        body_done;
  logic [9:0]  pre_total;

  assign idx      = apb_i.paddr[11:2];
  assign wr_en    = apb_i.psel && apb_i.penable && s.pready && apb_i.pwrite;
  assign rd_en    = apb_i.psel && apb_i.penable && !s.pready && !apb_i.pwrite;
  assign byte_end = bit_tick_i && (s.bitcnt == 3'h7);
  // A zero count stands for 256 bytes
  assign pre_total = ((s.preamble == 8'h00) ? 10'h100 : {2'b00, s.preamble})
                     + {2'b00, s.pre_extra};
  assign crc_n     = crc_step(s.crc, s.shreg[7]);
  // Length field counts every byte between sync and CRC, itself included
  assign body_total = (s.cnt == 10'h000) ? clamp_len({s.len_hi, pram_rdata_i}) : s.blen;
  assign body_done  = (s.cnt != 10'h000) && ({6'h00, s.cnt} + 16'h0001 >= body_total);

  always_comb begin
    mapped = 1'b1;
    rdval  = 32'h0000_0000;
    case (idx)
      IDX_PREAMBLE:  rdval = {24'h0, s.preamble};
      IDX_PRE_EXTRA: rdval = {24'h0, s.pre_extra};
      IDX_SYNC_LOW:  rdval = {24'h0, s.sync_low};
      IDX_SYNC_MID:  rdval = {24'h0, s.sync_mid};
      IDX_SYNC_HIGH: rdval = {24'h0, s.sync_high};
      IDX_RADIO_CFG: rdval = {24'h0, s.radio_cfg};
      IDX_PKT_CFG:   rdval = {24'h0, s.pkt_cfg};
      IDX_COMMAND:   rdval = 32'h0000_0000;
      IDX_STATUS:    rdval = {28'h0, (s.st != ST_IDLE), s.st};
      IDX_TX_BASE:   rdval = {24'h0, s.tx_base};
      default:       mapped = 1'b0;
    endcase
  end

  // ==========================================================================
  // Next state
  always_comb begin
    next_s           = s;
    next_s.ser_meta  = serial_bit_i;
    next_s.ser_sync  = s.ser_meta;
    next_s.cal_start = 1'b0;
    next_s.sfd_sent  = 1'b0;
    next_s.pkt_sent  = 1'b0;

    // APB: one wait state, write lands on the edge that completes the access
    next_s.pready  = apb_i.psel && apb_i.penable && !s.pready;
    next_s.pslverr = apb_i.psel && apb_i.penable && !s.pready && !mapped;
    if (rd_en) begin
      next_s.prdata = mapped ? rdval : 32'h0000_0000;
    end
    if (wr_en) begin
      case (idx)
        IDX_PREAMBLE:  next_s.preamble  = apb_i.pwdata[7:0];
        IDX_PRE_EXTRA: next_s.pre_extra = apb_i.pwdata[7:0];
        IDX_SYNC_LOW:  next_s.sync_low  = apb_i.pwdata[7:0];
        IDX_SYNC_MID:  next_s.sync_mid  = apb_i.pwdata[7:0];
        IDX_SYNC_HIGH: next_s.sync_high = apb_i.pwdata[7:0];
        IDX_RADIO_CFG: next_s.radio_cfg = apb_i.pwdata[7:0];
        IDX_PKT_CFG:   next_s.pkt_cfg   = apb_i.pwdata[7:0];
        IDX_TX_BASE:   next_s.tx_base   = apb_i.pwdata[7:0];
        default:       next_s.pkt_cfg   = s.pkt_cfg;
      endcase
    end

    case (s.st)
      ST_IDLE: begin
        if (wr_en && idx == IDX_COMMAND && apb_i.pwdata[CMD_TX_GO] &&
            (s.radio_cfg == MODE_PKT_TX || s.radio_cfg == MODE_RAW_TX)) begin
          next_s.st        = ST_CAL;
          next_s.cal_start = 1'b1;
          next_s.raw_mode  = (s.radio_cfg == MODE_RAW_TX);
        end
      end
      ST_CAL: begin
        if (cal_done_i) begin
          next_s.bitcnt = 3'h0;
          next_s.dly    = 2'b00;
          if (s.raw_mode) begin
            next_s.st    = ST_RAW;
            next_s.shreg = {s.ser_sync, 7'h00};
          end else begin
            next_s.st    = ST_PRE;
            next_s.shreg = PAD_BYTE;
            next_s.cnt   = pre_total;
            next_s.addr  = s.tx_base;
            next_s.crc   = CRC_INIT;
          end
        end
      end
      ST_RAW: begin
        if (bit_tick_i) begin
          next_s.dly   = {s.dly[0], s.ser_sync};
          next_s.shreg = {(s.pkt_cfg[PKT_CFG_GAUSS_EN] ? s.dly[1] : s.ser_sync), 7'h00};
        end
      end
      default: begin
        if (bit_tick_i) begin
          next_s.bitcnt = s.bitcnt + 3'h1;
          next_s.shreg  = {s.shreg[6:0], 1'b0};
          if (s.st == ST_BODY) begin
            next_s.crc = crc_n;
          end
        end
        if (byte_end) begin
          case (s.st)
            ST_PRE: begin
              if (s.cnt > 10'h001) begin
                next_s.cnt   = s.cnt - 10'h001;
                next_s.shreg = PAD_BYTE;
              end else begin
                next_s.st    = ST_SYNC;
                next_s.cnt   = 10'h002;
                next_s.shreg = s.sync_high;
              end
            end
            ST_SYNC: begin
              if (s.cnt != 10'h000) begin
                next_s.cnt   = s.cnt - 10'h001;
                next_s.shreg = (s.cnt == 10'h002) ? s.sync_mid : s.sync_low;
              end else begin
                next_s.st       = ST_BODY;
                next_s.cnt      = 10'h000;
                next_s.shreg    = pram_rdata_i;
                next_s.len_hi   = pram_rdata_i;
                next_s.addr     = s.addr + 8'h01;
                next_s.sfd_sent = 1'b1;
              end
            end
            ST_BODY: begin
              next_s.blen = body_total;
              if (body_done) begin
                if (s.pkt_cfg[PKT_CFG_CRC_OFF]) begin
                  next_s.st    = ST_POST;
                  next_s.cnt   = 10'h001;
                  next_s.shreg = PAD_BYTE;
                end else begin
                  next_s.st    = ST_CRC;
                  next_s.cnt   = 10'h001;
                  next_s.shreg = crc_n[15:8];
                end
              end else begin
                next_s.cnt   = s.cnt + 10'h001;
                next_s.shreg = pram_rdata_i;
                next_s.addr  = s.addr + 8'h01;
              end
            end
            ST_CRC: begin
              if (s.cnt != 10'h000) begin
                next_s.cnt   = 10'h000;
                next_s.shreg = s.crc[7:0];
              end else begin
                next_s.st    = ST_POST;
                next_s.cnt   = 10'h001;
                next_s.shreg = PAD_BYTE;
              end
            end
            ST_POST: begin
              if (s.cnt != 10'h000) begin
                next_s.cnt     = 10'h000;
                next_s.shreg   = PAD_BYTE;
                next_s.pa_down = 1'b1;
              end else begin
                next_s.st       = ST_IDLE;
                next_s.pa_down  = 1'b0;
                next_s.pkt_sent = 1'b1;
              end
            end
            default: begin
              next_s.st = ST_IDLE;
            end
          endcase
        end
      end
    endcase

    // Leave command ends any transmission at once
    if (wr_en && idx == IDX_COMMAND && apb_i.pwdata[CMD_LEAVE] && s.st != ST_IDLE) begin
      next_s.st       = ST_IDLE;
      next_s.pa_down  = 1'b0;
      next_s.sfd_sent = 1'b0;
      next_s.pkt_sent = 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      s           <= '0;
      s.st        <= ST_IDLE;
      s.preamble  <= RST_PREAMBLE;
      s.pre_extra <= RST_PRE_EXTRA;
      s.sync_low  <= RST_SYNC;
      s.sync_mid  <= RST_SYNC;
      s.sync_high <= RST_SYNC;
      s.radio_cfg <= RST_RADIO_CFG;
      s.pkt_cfg   <= RST_PKT_CFG;
      s.tx_base   <= RST_TX_BASE;
      s.crc       <= CRC_INIT;
    end else begin
      s <= next_s;
    end
  end

  // ==========================================================================
  // Outputs
  assign apb_o.prdata   = s.prdata;
  assign apb_o.pready   = s.pready;
  assign apb_o.pslverr  = s.pslverr;
  assign pram_addr_o    = s.addr;
  assign tx_bit_o       = s.shreg[7];
  assign tx_active_o    = (s.st != ST_IDLE) && (s.st != ST_CAL);
  assign cal_start_o    = s.cal_start;
  assign pa_ramp_down_o = s.pa_down;
  assign sfd_sent_o     = s.sfd_sent;
  assign pkt_sent_o     = s.pkt_sent;

  // ==========================================================================
  // Checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  logic [9:0] pre_seen;
  always_ff @(posedge clk_i) begin
    if (!rst_n_i || s.st != ST_PRE) begin
      pre_seen <= 10'h000;
    end else if (byte_end) begin
      pre_seen <= pre_seen + 10'h001;
    end
  end

  sequence s_byte_end;
    bit_tick_i && s.bitcnt == 3'h7;
  endsequence

  sequence s_pre_leaves;
    s.st == ST_PRE ##0 s_byte_end ##1 s.st != ST_PRE;
  endsequence

  property p_pre_pattern;
    (s.st == ST_PRE && s.bitcnt == 3'h0) |-> s.shreg == PAD_BYTE;
  endproperty
  a_pre_pattern: assert property (p_pre_pattern) else $error("preamble byte not 0xaa");

  property p_pre_count;
    (s.st == ST_PRE) ##0 s_byte_end |=> (s.st == ST_PRE) || ($past(pre_seen) + 10'h001 == pre_total);
  endproperty
  a_pre_count: assert property (p_pre_count) else $error("wrong preamble byte count");

  property p_sync_first;
    s_pre_leaves |-> s.st == ST_SYNC && s.shreg == s.sync_high && s.bitcnt == 3'h0;
  endproperty
  a_sync_first: assert property (p_sync_first) else $error("sync does not start with high byte");

  property p_crc_only_on;
    (s.st == ST_BODY ##1 s.st == ST_CRC) |-> !s.pkt_cfg[PKT_CFG_CRC_OFF];
  endproperty
  a_crc_only_on: assert property (p_crc_only_on) else $error("crc sent while disabled");

  property p_post_pattern;
    (s.st == ST_POST && s.bitcnt == 3'h0) |-> s.shreg == PAD_BYTE;
  endproperty
  a_post_pattern: assert property (p_post_pattern) else $error("postamble byte not 0xaa");

  property p_ramp_down;
    $rose(pa_ramp_down_o) |-> s.st == ST_POST && s.cnt == 10'h000 && s.bitcnt == 3'h0;
  endproperty
  a_ramp_down: assert property (p_ramp_down) else $error("ramp-down not after first postamble");

  property p_raw_quiet;
    s.raw_mode |-> !sfd_sent_o && !pkt_sent_o;
  endproperty
  a_raw_quiet: assert property (p_raw_quiet) else $error("framing event in raw mode");

  property p_cal_entry;
    (s.st == ST_IDLE ##1 s.st == ST_CAL) |-> cal_start_o ##1 !cal_start_o;
  endproperty
  a_cal_entry: assert property (p_cal_entry) else $error("calibration not started on entry");

  property p_raw_stays;
    (s.st == ST_RAW ##1 s.st != ST_RAW) |-> $past(wr_en && idx == IDX_COMMAND && apb_i.pwdata[CMD_LEAVE]);
  endproperty
  a_raw_stays: assert property (p_raw_stays) else $error("raw mode left without command");

  property p_sfd_after_sync;
    sfd_sent_o |-> $past(s.st) == ST_SYNC && s.st == ST_BODY;
  endproperty
  a_sfd_after_sync: assert property (p_sfd_after_sync) else $error("sync event misplaced");

endmodule

/* File: sim/modulator_model.sv */
// Behavioural modulator, calibration engine and packet RAM facing the transmit framer.
// Assumes one clock shared with the framer; the bench loads mem directly.
`timescale 1ns/1ps

module modulator_model #(
  parameter int TICK_DIV = 4,
  parameter int CAL_DLY  = 6
) (
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  // Framer side
  input  wire logic       cal_start_i,
  input  wire logic [7:0] pram_addr_i,
  output      logic       bit_tick_o,
  output      logic       cal_done_o,
  output      logic [7:0] pram_rdata_o
);
  logic [7:0] mem [256];
  int         div_cnt;
  int         cal_cnt;

  // ==========================================================================
  // Bit clock, calibration delay and one-cycle RAM read
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      div_cnt    <= 0;
      bit_tick_o <= 1'b0;
      cal_cnt    <= 0;
      cal_done_o <= 1'b0;
    end else begin
      div_cnt    <= (div_cnt == TICK_DIV - 1) ? 0 : div_cnt + 1;
      bit_tick_o <= (div_cnt == TICK_DIV - 1);
      cal_done_o <= (cal_cnt == 1);
      if (cal_start_i) begin
        cal_cnt <= CAL_DLY;
      end else if (cal_cnt != 0) begin
        cal_cnt <= cal_cnt - 1;
      end
    end
    pram_rdata_o <= mem[pram_addr_i];
  end
endmodule

/* File: sim/fsk_tx_packet_framer_bench.sv */
// Self-checking bench for the transmit framer: APB registers, packet framing, raw mode.
// Assumes the modulator model in modulator_model.sv.
`timescale 1ns/1ps

module fsk_tx_packet_framer_bench;
  import fsk_tx_pkg::*;
  logic       clk_i, rst_n_i, bit_tick_i, serial_bit_i, cal_done_i;
  apb_req_t   apb_i;
  apb_rsp_t   apb_o;
  logic [7:0] pram_addr_o, pram_rdata_i, exp_q[$];
  logic       tx_bit_o, tx_active_o, cal_start_o, pa_ramp_down_o, sfd_sent_o, pkt_sent_o;
  logic       cap_on, cap_q[$], pa_q[$];
  int         bad_count, checks, cycles, sfd_cnt, sfd_pos, pkt_cnt, pkt_pos, cal_cnt;

  fsk_tx_packet_framer uut (.clk_i(clk_i), .rst_n_i(rst_n_i), .apb_i(apb_i), .apb_o(apb_o),
    .pram_addr_o(pram_addr_o), .pram_rdata_i(pram_rdata_i), .bit_tick_i(bit_tick_i),
    .serial_bit_i(serial_bit_i), .cal_done_i(cal_done_i), .tx_bit_o(tx_bit_o), .tx_active_o(tx_active_o),
    .cal_start_o(cal_start_o), .pa_ramp_down_o(pa_ramp_down_o), .sfd_sent_o(sfd_sent_o),
    .pkt_sent_o(pkt_sent_o));
  modulator_model mdl (.clk_i(clk_i), .rst_n_i(rst_n_i), .cal_start_i(cal_start_o),
    .pram_addr_i(pram_addr_o), .bit_tick_o(bit_tick_i), .cal_done_o(cal_done_i), .pram_rdata_o(pram_rdata_i));

  // ==========================================================================
  // Clock, timeout and line monitor
  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 40000) begin
      bad_count++;
      tally_and_finish();
    end
  end
  // Sampled mid-cycle so design outputs have settled
  always @(negedge clk_i) begin
    if (cap_on && tx_active_o === 1'b1 && bit_tick_i) begin
      cap_q.push_back(tx_bit_o);
      pa_q.push_back(pa_ramp_down_o);
    end
    if (sfd_sent_o === 1'b1) begin
      sfd_cnt++;
      sfd_pos = cap_q.size();
    end
    if (pkt_sent_o === 1'b1) begin
      pkt_cnt++;
      pkt_pos = cap_q.size();
    end
    if (cal_start_o === 1'b1) cal_cnt++;
  end

  // ==========================================================================
  // Shared tasks
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic apb_xfer(input logic [9:0] idx, input logic wr, input logic [31:0] wd,
                          output logic [31:0] rd, output logic err);
    int n;
    @(posedge clk_i);
    apb_i.psel    <= 1'b1;
    apb_i.penable <= 1'b0;
    apb_i.pwrite  <= wr;
    apb_i.paddr   <= {idx, 2'b00};
    apb_i.pwdata  <= wd;
    @(posedge clk_i);
    apb_i.penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (apb_o.pready !== 1'b1 && n < 20);
    rd = apb_o.prdata;
    err = apb_o.pslverr;
    apb_i.psel    <= 1'b0;
    apb_i.penable <= 1'b0;
    if (n >= 20) chk("pready", 32'h1, 32'h0);
  endtask

  task automatic apb_wr(input logic [9:0] idx, input logic [31:0] wd);
    logic [31:0] rd;
    logic        err;
    apb_xfer(idx, 1'b1, wd, rd, err);
  endtask

  task automatic wait_tick(input int k);
    repeat (k) @(posedge clk_i iff bit_tick_i);
  endtask

  task automatic clear_mon();
    cap_q.delete();
    pa_q.delete();
    sfd_cnt = 0;
    pkt_cnt = 0;
    cal_cnt = 0;
    sfd_pos = 0;
    pkt_pos = 0;
  endtask

  function automatic logic [15:0] crc16(input logic [7:0] q[$]);
    logic [15:0] c;
    c = CRC_INIT;
    foreach (q[i]) for (int b = 7; b >= 0; b--) c = {c[14:0], 1'b0} ^ ((c[15] ^ q[i][b]) ? CRC_POLY : 16'h0000);
    return c;
  endfunction

  // ==========================================================================
  // Scenarios
  task automatic test_regs();
    logic [9:0]  idx [8] = '{IDX_PREAMBLE, IDX_PRE_EXTRA, IDX_SYNC_LOW, IDX_SYNC_MID, IDX_SYNC_HIGH,
                             IDX_RADIO_CFG, IDX_PKT_CFG, IDX_TX_BASE};
    logic [7:0]  rv [8] = '{RST_PREAMBLE, RST_PRE_EXTRA, RST_SYNC, RST_SYNC, RST_SYNC, RST_RADIO_CFG,
                            RST_PKT_CFG, RST_TX_BASE};
    logic [31:0] rd;
    logic        err;
    foreach (idx[i]) begin
      apb_xfer(idx[i], 1'b0, 32'h0, rd, err);
      chk("reset value", {24'h0, rv[i]}, rd);
      chk("reset slverr", 32'h0, {31'h0, err});
    end
    apb_xfer(10'h001, 1'b0, 32'h0, rd, err);
    chk("unmapped slverr", 32'h1, {31'h0, err});
    chk("unmapped data", 32'h0, rd);
    apb_wr(IDX_PREAMBLE, 32'hffffff37);
    apb_xfer(IDX_PREAMBLE, 1'b0, 32'h0, rd, err);
    chk("preamble readback", 32'h37, rd);
    $display("test regs done");
  endtask

  task automatic pkt_test(input string nm, input logic [7:0] pre, ext, s2, s1, s0, base,
                          input logic crc_off, input logic [7:0] body[$]);
    int          n, bad_at, ones, n_pre;
    logic [15:0] crc;
    apb_wr(IDX_PREAMBLE, {24'h0, pre});
    apb_wr(IDX_PRE_EXTRA, {24'h0, ext});
    apb_wr(IDX_SYNC_HIGH, {24'h0, s2});
    apb_wr(IDX_SYNC_MID, {24'h0, s1});
    apb_wr(IDX_SYNC_LOW, {24'h0, s0});
    apb_wr(IDX_TX_BASE, {24'h0, base});
    apb_wr(IDX_PKT_CFG, {31'h0, crc_off});
    foreach (body[i]) mdl.mem[8'(base + i)] = body[i];
    n_pre = ((pre == 8'h00) ? 256 : int'(pre)) + int'(ext);
    exp_q.delete();
    repeat (n_pre) exp_q.push_back(PAD_BYTE);
    exp_q.push_back(s2);
    exp_q.push_back(s1);
    exp_q.push_back(s0);
    foreach (body[i]) exp_q.push_back(body[i]);
    crc = crc16(body);
    if (!crc_off) begin
      exp_q.push_back(crc[15:8]);
      exp_q.push_back(crc[7:0]);
    end
    exp_q.push_back(PAD_BYTE);
    exp_q.push_back(PAD_BYTE);
    clear_mon();
    cap_on = 1'b1;
    apb_wr(IDX_RADIO_CFG, {24'h0, MODE_PKT_TX});
    apb_wr(IDX_COMMAND, 32'h1 << CMD_TX_GO);
    n = 0;
    while (pkt_cnt == 0 && n < 30000) begin
      @(posedge clk_i);
      n++;
    end
    if (n >= 30000) chk("pkt sent wait", 32'h1, 32'h0);
    repeat (4) @(posedge clk_i);
    cap_on = 1'b0;
    chk("bit count", exp_q.size() * 8, cap_q.size());
    bad_at = -1;
    foreach (cap_q[i]) if (bad_at < 0 && i < exp_q.size() * 8 && cap_q[i] !== exp_q[i / 8][7 - i % 8]) bad_at = i;
    chk("first wrong bit", 32'hffffffff, bad_at);
    ones = 0;
    foreach (pa_q[i]) if (pa_q[i] === 1'b1) ones++;
    chk("ramp bits", 32'd8, ones);
    if (pa_q.size() >= 8) chk("ramp start", 32'h1, {31'h0, pa_q[pa_q.size() - 8]});
    chk("sfd count", 32'h1, sfd_cnt);
    chk("sfd position", (n_pre + 3) * 8, sfd_pos);
    chk("pkt sent count", 32'h1, pkt_cnt);
    chk("pkt sent position", exp_q.size() * 8, pkt_pos);
    chk("cal start count", 32'h1, cal_cnt);
    $display("test %s done", nm);
  endtask

  task automatic raw_test(input logic gauss);
    logic       bits [3] = '{1'b1, 1'b0, 1'b1};
    logic       prev;
    int         n;
    logic [31:0] rd;
    logic        err;
    clear_mon();
    apb_wr(IDX_PKT_CFG, {30'h0, gauss, 1'b0});
    serial_bit_i <= 1'b0;
    apb_wr(IDX_RADIO_CFG, {24'h0, MODE_RAW_TX});
    apb_wr(IDX_COMMAND, 32'h1 << CMD_TX_GO);
    n = 0;
    while (tx_active_o !== 1'b1 && n < 200) begin
      @(negedge clk_i);
      n++;
    end
    chk("raw active", 32'h1, {31'h0, tx_active_o});
    apb_xfer(IDX_STATUS, 1'b0, 32'h0, rd, err);
    chk("raw status", (32'h1 << STATUS_BUSY) | 32'(ST_RAW), rd);
    wait_tick(4);
    prev = 1'b0;
    foreach (bits[i]) begin
      wait_tick(1);
      serial_bit_i <= bits[i];
      wait_tick(1);
      @(negedge clk_i);
      chk("raw bit after one tick", {31'h0, gauss ? prev : bits[i]}, {31'h0, tx_bit_o});
      wait_tick(2);
      @(negedge clk_i);
      chk("raw bit after three ticks", {31'h0, bits[i]}, {31'h0, tx_bit_o});
      prev = bits[i];
    end
    apb_wr(IDX_COMMAND, 32'h1 << CMD_LEAVE);
    repeat (2) @(negedge clk_i);
    chk("raw left", 32'h0, {31'h0, tx_active_o});
    chk("raw sfd events", 32'h0, sfd_cnt);
    chk("raw pkt events", 32'h0, pkt_cnt);
    chk("raw cal start", 32'h1, cal_cnt);
    $display("test raw gauss=%0d done", gauss);
  endtask

  // ==========================================================================
  // Main sequence
  initial begin
    apb_i = '0;
    serial_bit_i = 1'b0;
    rst_n_i = 1'b0;
    cap_on = 1'b0;
    bad_count = 0;
    checks = 0;
    cycles = 0;
    repeat (4) @(posedge clk_i);
    rst_n_i <= 1'b1;
    test_regs();
    pkt_test("crc", 8'h01, 8'h01, 8'h12, 8'h34, 8'h56, 8'h10, 1'b0, '{8'h00, 8'h04, 8'hde, 8'had});
    pkt_test("nocrc", 8'h00, 8'h02, 8'haa, 8'haa, 8'h9c, 8'hf0, 1'b1, '{8'h00, 8'h03, 8'h5a});
    raw_test(1'b0);
    raw_test(1'b1);
    tally_and_finish();
  end
endmodule
